// ==== hdl/uap_regs.vh ====
`ifndef UAP_REGS_VH
`define UAP_REGS_VH
// register byte addresses
`define UAP_ADDR_CTRL 8'h00
`define UAP_ADDR_STAT 8'h04
`define UAP_ADDR_IRQ_STAT 8'h08
`define UAP_ADDR_IRQ_MASK 8'h0c
`define UAP_ADDR_BCD_MAP 8'h10
`define UAP_ADDR_BUTTON 8'h14
// ctrl fields
`define UAP_CTRL_VBUS_SEL 0
`define UAP_CTRL_UART_MODE 1
`define UAP_CTRL_CONFIGURED 2
`define UAP_CTRL_SUSPENDED 3
`define UAP_CTRL_BCD_START 4
`define UAP_CTRL_CHG_LSB 5
`define UAP_CTRL_RX_PULSE 7
`define UAP_CTRL_TX_PULSE 8
`define UAP_CTRL_TXPEND 9
`define UAP_CTRL_RESET 10'h000
// status fields
`define UAP_STAT_VBUS 0
`define UAP_STAT_PULLUP 1
`define UAP_STAT_BCD_DONE 2
`define UAP_STAT_CHG_LSB 3
// irq bits
`define UAP_IRQ_ATTACH 0
`define UAP_IRQ_DETACH 1
`define UAP_IRQ_BCD_DONE 2
`define UAP_IRQ_WAKE 3
`define UAP_IRQ_W 4
// charger types
`define UAP_CHG_NONE 2'h0
`define UAP_CHG_SDP 2'h1
`define UAP_CHG_CDP 2'h2
`define UAP_CHG_DCP 2'h3
// default output encoding: none,sdp,cdp/dcp,suspend (2 bits each)
`define UAP_BCD_MAP_RESET 8'he4
// timing
`define UAP_FILT_CYCLES 4'h4
// led pulse and wakeup pulse lengths in 10 ns clock cycles, sized for the 8-bit timers
`define UAP_LED_CYCLES 8'h64
`define UAP_WAKE_CYCLES 8'hc8
`endif

// ==== hdl/uap_attach.v ====
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "uap_regs.vh"
// Contract
// - pull-up on only while vbus present
// - chip reset tristates all pins
// - suspend output while suspended or unconfigured
// - wake input triggers remote wakeup signalling while attached and suspended
// - vbus attach starts charger detect, reports type
// - pull-up only for sdp or cdp
// - vbus removal reports no charger, drops pull-up
// - charger outputs use configurable encoding
// - power switch low only when configured
// - active-low rx/tx activity led pulses
// - driver enable while uart tx pending
// - selected gpio sense replaces vbus pin
// - button index outputs show pressed button
module uap_attach (
   // clock and reset
   input wire aclk,
   input wire aresetn,
   input wire chip_reset_n,
   // axi4-lite write
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // axi4-lite read
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // sense inputs
   input wire vbus_pin,
   input wire vbus_sense_input,
   input wire wake_in,
   input wire [1:0] charger_class,
   input wire charger_class_valid,
   // usb side
   output reg usb_plus_pullup_en,
   output reg remote_wakeup,
   // pins with enables
   output reg charger_type_bit0,
   output reg charger_type_bit1,
   output reg suspend_out,
   output reg power_switch_n,
   output reg rx_activity_led_n,
   output reg tx_activity_led_n,
   output reg line_driver_enable,
   output reg button_index_out0,
   output reg button_index_out1,
   output reg button_index_out2,
   output reg pins_oe,
   output reg irq
);
   localparam ST_DETACHED = 2'h0;
   localparam ST_DETECT = 2'h1;
   localparam ST_ATTACHED = 2'h2;

   reg [9:0] ctrl;
   reg [7:0] bcd_map;
   reg [2:0] button;
   reg [3:0] irq_stat;
   reg [3:0] irq_mask;
   reg [1:0] state;
   reg [1:0] chg;
   reg bcd_done;
   reg [1:0] rst_sync;
   reg vbus_p0, vbus_p1, sense_p0, sense_p1, wake_p0, wake_p1;
   reg [3:0] vbus_cnt, wake_cnt;
   reg vbus_f, wake_f, wake_f_d;
   reg [7:0] rx_cnt, tx_cnt;
   reg [7:0] wake_tmr;
   reg aw_hold, w_hold;
   reg [7:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg [3:0] irq_set;
   reg [1:0] enc;
   wire vbus_raw;
   wire hold_reset;
   wire wr_go;

   // chip reset pin passes two flops before use
   always @(posedge aclk) begin
      if (!aresetn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], chip_reset_n};
      end
   end
   assign hold_reset = ~rst_sync[1];

   // pin synchronisers
   always @(posedge aclk) begin
      if (!aresetn) begin
         vbus_p0 <= 1'b0;
         vbus_p1 <= 1'b0;
         sense_p0 <= 1'b0;
         sense_p1 <= 1'b0;
         wake_p0 <= 1'b0;
         wake_p1 <= 1'b0;
      end else begin
         vbus_p0 <= vbus_pin;
         vbus_p1 <= vbus_p0;
         sense_p0 <= vbus_sense_input;
         sense_p1 <= sense_p0;
         wake_p0 <= wake_in;
         wake_p1 <= wake_p0;
      end
   end

   // source choice for vbus presence
   assign vbus_raw = ctrl[`UAP_CTRL_VBUS_SEL] ? sense_p1 : vbus_p1;

   // glitch filters: level must persist before it is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         vbus_cnt <= 4'h0;
         wake_cnt <= 4'h0;
         vbus_f <= 1'b0;
         wake_f <= 1'b0;
         wake_f_d <= 1'b0;
      end else begin
         wake_f_d <= wake_f;
         if (vbus_raw == vbus_f) begin
            vbus_cnt <= 4'h0;
         end else if (vbus_cnt == `UAP_FILT_CYCLES - 4'h1) begin
            vbus_cnt <= 4'h0;
            vbus_f <= vbus_raw;
         end else begin
            vbus_cnt <= vbus_cnt + 4'h1;
         end
         if (wake_p1 == wake_f) begin
            wake_cnt <= 4'h0;
         end else if (wake_cnt == `UAP_FILT_CYCLES - 4'h1) begin
            wake_cnt <= 4'h0;
            wake_f <= wake_p1;
         end else begin
            wake_cnt <= wake_cnt + 4'h1;
         end
      end
   end

   // attach state machine with charger detection
   always @(posedge aclk) begin
      if (!aresetn || hold_reset) begin
         state <= ST_DETACHED;
         chg <= `UAP_CHG_NONE;
         bcd_done <= 1'b0;
      end else begin
         case (state)
            ST_DETACHED: begin
               chg <= `UAP_CHG_NONE;
               bcd_done <= 1'b0;
               if (vbus_f) begin
                  state <= ST_DETECT;
               end
            end
            ST_DETECT: begin
               if (!vbus_f) begin
                  state <= ST_DETACHED;
               end else if (charger_class_valid) begin
                  chg <= charger_class;
                  bcd_done <= 1'b1;
                  state <= ST_ATTACHED;
               end
            end
            ST_ATTACHED: begin
               if (!vbus_f) begin
                  chg <= `UAP_CHG_NONE;
                  bcd_done <= 1'b0;
                  state <= ST_DETACHED;
               end
            end
            default: begin
               state <= ST_DETACHED;
            end
         endcase
      end
   end

   // axi write side: address and data in any order
   assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         aw_hold <= 1'b0;
         w_hold <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         ctrl <= `UAP_CTRL_RESET;
         bcd_map <= `UAP_BCD_MAP_RESET;
         button <= 3'h0;
         irq_mask <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
         if (wr_go) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'h0;
            case (aw_addr)
               `UAP_ADDR_CTRL: begin
                  if (w_strb[0]) ctrl[7:0] <= w_data[7:0];
                  if (w_strb[1]) ctrl[9:8] <= w_data[9:8];
               end
               `UAP_ADDR_IRQ_MASK: begin
                  if (w_strb[0]) irq_mask <= w_data[3:0];
               end
               `UAP_ADDR_BCD_MAP: begin
                  if (w_strb[0]) bcd_map <= w_data[7:0];
               end
               `UAP_ADDR_BUTTON: begin
                  if (w_strb[0]) button <= w_data[2:0];
               end
               `UAP_ADDR_IRQ_STAT, `UAP_ADDR_STAT: begin
                  s_axi_bresp <= 2'h0;
               end
               default: begin
                  s_axi_bresp <= 2'h2;
               end
            endcase
         end
      end
   end

   // sticky events, write one to clear, set beats clear
   always @* begin
      irq_set = 4'h0;
      irq_set[`UAP_IRQ_ATTACH] = (state == ST_DETACHED) && vbus_f;
      irq_set[`UAP_IRQ_DETACH] = (state != ST_DETACHED) && !vbus_f;
      irq_set[`UAP_IRQ_BCD_DONE] = (state == ST_DETECT) && vbus_f && charger_class_valid;
      irq_set[`UAP_IRQ_WAKE] = wake_f && !wake_f_d;
   end
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq_stat <= 4'h0;
         irq <= 1'b0;
      end else begin
         if (wr_go && aw_addr == `UAP_ADDR_IRQ_STAT && w_strb[0]) begin
            irq_stat <= (irq_stat & ~w_data[3:0]) | irq_set;
         end else begin
            irq_stat <= irq_stat | irq_set;
         end
         irq <= |(irq_stat & ~irq_mask); // a set mask bit blocks its event
      end
   end

   // axi read side
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end else if (s_axi_arvalid) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'h0;
         s_axi_rdata <= 32'h00000000;
         case (s_axi_araddr)
            `UAP_ADDR_CTRL: s_axi_rdata[9:0] <= ctrl;
            `UAP_ADDR_STAT: s_axi_rdata[4:0] <= {chg, bcd_done, usb_plus_pullup_en, vbus_f};
            `UAP_ADDR_IRQ_STAT: s_axi_rdata[3:0] <= irq_stat;
            `UAP_ADDR_IRQ_MASK: s_axi_rdata[3:0] <= irq_mask;
            `UAP_ADDR_BCD_MAP: s_axi_rdata[7:0] <= bcd_map;
            `UAP_ADDR_BUTTON: s_axi_rdata[2:0] <= button;
            default: s_axi_rresp <= 2'h2;
         endcase
      end
   end

   // charger code through the configurable map
   always @* begin
      if (ctrl[`UAP_CTRL_SUSPENDED] && state == ST_ATTACHED) begin
         enc = bcd_map[7:6];
      end else if (chg == `UAP_CHG_SDP) begin
         enc = bcd_map[3:2];
      end else if (chg == `UAP_CHG_CDP || chg == `UAP_CHG_DCP) begin
         enc = bcd_map[5:4];
      end else begin
         enc = bcd_map[1:0];
      end
   end

   // pin outputs, activity leds and remote wakeup timing
   always @(posedge aclk) begin
      if (!aresetn) begin
         usb_plus_pullup_en <= 1'b0;
         charger_type_bit0 <= 1'b0;
         charger_type_bit1 <= 1'b0;
         suspend_out <= 1'b1;
         power_switch_n <= 1'b1;
         rx_activity_led_n <= 1'b1;
         tx_activity_led_n <= 1'b1;
         line_driver_enable <= 1'b0;
         button_index_out0 <= 1'b0;
         button_index_out1 <= 1'b0;
         button_index_out2 <= 1'b0;
         pins_oe <= 1'b0;
         remote_wakeup <= 1'b0;
         rx_cnt <= 8'h00;
         tx_cnt <= 8'h00;
         wake_tmr <= 8'h00;
      end else begin
         pins_oe <= ~hold_reset;
         usb_plus_pullup_en <= ~hold_reset && vbus_f && state == ST_ATTACHED &&
            (chg == `UAP_CHG_SDP || chg == `UAP_CHG_CDP);
         charger_type_bit0 <= enc[0];
         charger_type_bit1 <= enc[1];
         suspend_out <= ctrl[`UAP_CTRL_SUSPENDED] || !ctrl[`UAP_CTRL_CONFIGURED];
         power_switch_n <= ctrl[`UAP_CTRL_SUSPENDED] || !ctrl[`UAP_CTRL_CONFIGURED];
         line_driver_enable <= ctrl[`UAP_CTRL_UART_MODE] && ctrl[`UAP_CTRL_TXPEND];
         button_index_out0 <= button[0];
         button_index_out1 <= button[1];
         button_index_out2 <= button[2];
         if (ctrl[`UAP_CTRL_RX_PULSE]) begin
            rx_cnt <= `UAP_LED_CYCLES;
         end else if (rx_cnt != 8'h00) begin
            rx_cnt <= rx_cnt - 8'h01;
         end
         if (ctrl[`UAP_CTRL_TX_PULSE]) begin
            tx_cnt <= `UAP_LED_CYCLES;
         end else if (tx_cnt != 8'h00) begin
            tx_cnt <= tx_cnt - 8'h01;
         end
         rx_activity_led_n <= ~(ctrl[`UAP_CTRL_RX_PULSE] || rx_cnt != 8'h00);
         tx_activity_led_n <= ~(ctrl[`UAP_CTRL_TX_PULSE] || tx_cnt != 8'h00);
         if (wake_f && !wake_f_d && ctrl[`UAP_CTRL_SUSPENDED] && state == ST_ATTACHED) begin
            wake_tmr <= `UAP_WAKE_CYCLES;
         end else if (wake_tmr != 8'h00) begin
            wake_tmr <= wake_tmr - 8'h01;
         end
         remote_wakeup <= wake_tmr != 8'h00;
      end
   end
endmodule

// ==== testbench/uap_chk.sv ====
`timescale 1ns/1ps
module uap_chk (
   // clock and resets
   input wire aclk,
   input wire aresetn,
   input wire chip_reset_n,
   // bus handshakes
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   // attach and power pins
   input wire vbus_pin,
   input wire vbus_sense_input,
   input wire [1:0] charger_class,
   input wire usb_plus_pullup_en,
   input wire remote_wakeup,
   input wire suspend_out,
   input wire power_switch_n,
   input wire pins_oe
);
   // one clock domain for every check
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   a_reset_float: assert property (!chip_reset_n [*4] |-> !pins_oe)
      else $error("pins driven in chip reset");
   a_reset_pullup: assert property (!chip_reset_n [*4] |-> !usb_plus_pullup_en)
      else $error("pull-up on in chip reset");
   a_detach_pullup: assert property
      (!(vbus_pin || vbus_sense_input) [*8] |-> ##2 !usb_plus_pullup_en)
      else $error("pull-up on without vbus");
   a_pullup_type: assert property
      ($rose(usb_plus_pullup_en) |-> charger_class == 2'h1 || charger_class == 2'h2)
      else $error("pull-up on for wrong charger");
   a_power_suspend: assert property (power_switch_n == suspend_out)
      else $error("power switch and suspend disagree");
   a_wake_suspended: assert property ($rose(remote_wakeup) |-> suspend_out)
      else $error("wakeup outside suspend");
   a_wake_width: assert property ($rose(remote_wakeup) |-> remote_wakeup [*8])
      else $error("wakeup pulse too short");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_write_close: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response held");
endmodule
bind uap_attach uap_chk chk (.aclk, .aresetn, .chip_reset_n, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_bvalid, .s_axi_bready, .vbus_pin, .vbus_sense_input, .charger_class,
   .usb_plus_pullup_en, .remote_wakeup, .suspend_out, .power_switch_n, .pins_oe);

// ==== testbench/uap_charger_model.sv ====
`timescale 1ns/1ps
module uap_charger_model (
   // clock
   input wire aclk,
   // attach and scenario knobs
   input wire vbus,
   input wire [1:0] kind,
   input wire [5:0] lag,
   // detection result
   output reg [1:0] charger_class = 2'h0,
   output reg charger_class_valid = 1'h0
);
   reg [6:0] cnt = 7'h00;
   // classify lag cycles after attach, lines toggle while not valid
   always @(posedge aclk) begin
      cnt <= !vbus ? 7'h00 : cnt == 7'h7f ? cnt : cnt + 7'h01;
      charger_class_valid <= vbus && cnt >= {1'h0, lag};
      charger_class <= vbus && cnt >= {1'h0, lag} ? kind : ~charger_class;
   end
endmodule

// ==== testbench/usb_attach_power_signaling_test.sv ====
`timescale 1ns/1ps
`include "uap_regs.vh"
module usb_attach_power_signaling_test;
   // stimulus
   reg aclk = 1'h0, aresetn = 1'h0, chip_reset_n = 1'h1;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hf;
   reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   reg vbus_pin = 1'h0, vbus_sense_input = 1'h0, wake_in = 1'h0;
   reg [1:0] kind = 2'h0;
   reg [5:0] lag = 6'h00;
   // observed
   wire [1:0] charger_class, s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire charger_class_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, usb_plus_pullup_en, remote_wakeup, charger_type_bit0, charger_type_bit1;
   wire suspend_out, power_switch_n, rx_activity_led_n, tx_activity_led_n, line_driver_enable;
   wire button_index_out0, button_index_out1, button_index_out2, pins_oe, irq;
   wire [1:0] chg = {charger_type_bit1, charger_type_bit0};
   wire [1:0] led = {rx_activity_led_n, tx_activity_led_n};
   wire [1:0] pwr = {suspend_out, power_switch_n};
   wire [2:0] btn = {button_index_out2, button_index_out1, button_index_out0};
   integer failures = 0, n_checks = 0, i, t;
   reg [31:0] seed = 32'h0000b68d, d;
   reg [1:0] r;
   reg [7:0] map;
   // devices
   uap_attach dut (.aclk, .aresetn, .chip_reset_n, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vbus_pin, .vbus_sense_input,
      .wake_in, .charger_class, .charger_class_valid, .usb_plus_pullup_en, .remote_wakeup,
      .charger_type_bit0, .charger_type_bit1, .suspend_out, .power_switch_n,
      .rx_activity_led_n, .tx_activity_led_n, .line_driver_enable, .button_index_out0,
      .button_index_out1, .button_index_out2, .pins_oe, .irq);
   uap_charger_model pm (.aclk, .vbus(vbus_pin | vbus_sense_input), .kind, .lag,
      .charger_class, .charger_class_valid);
   // 100 mhz clock
   always #5 aclk = ~aclk;
   function [31:0] xs(input [31:0] s);
      reg [31:0] x;
      begin
         x = s ^ (s << 13);
         x = x ^ (x >> 17);
         xs = x ^ (x << 5);
      end
   endfunction
   // expected charger code from the map: none, sdp, cdp or dcp
   function [1:0] enc(input [7:0] m, input [1:0] k);
      enc = k == 2'h0 ? m[1:0] : k == 2'h1 ? m[3:2] : m[5:4];
   endfunction
   task cyc(input integer n);
      repeat (n) @(posedge aclk);
   endtask
   task ck(input [31:0] e, input [31:0] g, input [8*12:1] n);
      begin
         n_checks = n_checks + 1;
         if (g !== e) begin
            failures = failures + 1;
            $display("ERROR %0s expected %h seen %h", n, e, g);
         end
      end
   endtask
   // write: address and data released as taken, then the response
   task wr(input [7:0] a, input [31:0] v);
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'h1;
         s_axi_wvalid <= 1'h1;
         s_axi_bready <= 1'h1;
         t = 0;
         // only the watchdog ends a wait that never gets its answer
         while (t == 0) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) begin
               r = s_axi_bresp;
               s_axi_bready <= 1'h0;
               t = 1;
            end
         end
         cyc(2);
      end
   endtask
   task rd(input [7:0] a);
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'h1;
         s_axi_rready <= 1'h1;
         t = 0;
         while (t == 0) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) begin
               d = s_axi_rdata;
               r = s_axi_rresp;
               s_axi_rready <= 1'h0;
               t = 1;
            end
         end
      end
   endtask
   task end_of_test;
      begin
         $display("checks %0d failures %0d", n_checks, failures);
         if (failures == 0 && n_checks > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      #100000;
      failures = failures + 1;
      end_of_test;
   end
   // scenarios
   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      cyc(8);
      rd(`UAP_ADDR_BCD_MAP);
      ck(`UAP_BCD_MAP_RESET, d, "map_reset");
      rd(8'h18);
      ck(32'h2, {d[29:0], r}, "unmapped");
      wr(8'h18, 32'h0);
      ck(2'h2, r, "wr_unmapped");
      ck(6'h3c, {pwr, led, chg}, "pins_reset");
      vbus_pin <= 1'h1;
      cyc(2);
      vbus_pin <= 1'h0;
      cyc(20);
      rd(`UAP_ADDR_STAT);
      ck(1'h0, d[`UAP_STAT_VBUS], "glitch");
      // a glitch that got through would have left the attach event behind
      rd(`UAP_ADDR_IRQ_STAT);
      ck(32'h0, d, "glitch_irq");
      for (i = 0; i < 6; i = i + 1) begin
         seed = xs(seed);
         kind <= i < 4 ? i[1:0] : seed[1:0];
         lag <= seed[9:4];
         map = i == 0 ? `UAP_BCD_MAP_RESET : seed[23:16];
         wr(`UAP_ADDR_BCD_MAP, {24'h0, map});
         vbus_pin <= 1'h1;
         cyc(90);
         ck(kind == 2'h1 || kind == 2'h2, usb_plus_pullup_en, "pullup");
         ck(enc(map, kind), chg, "chg_type");
         vbus_pin <= 1'h0;
         cyc(20);
         ck({map[1:0], 1'h0}, {chg, usb_plus_pullup_en}, "detach");
      end
      rd(`UAP_ADDR_IRQ_STAT);
      ck(32'h7, d, "irq_stat");
      wr(`UAP_ADDR_IRQ_MASK, 32'h0);
      ck(1'h1, irq, "irq_on");
      wr(`UAP_ADDR_IRQ_MASK, 32'hf);
      ck(1'h0, irq, "irq_masked");
      wr(`UAP_ADDR_IRQ_STAT, 32'h7);
      wr(`UAP_ADDR_IRQ_MASK, 32'h0);
      rd(`UAP_ADDR_IRQ_STAT);
      ck(32'h0, {d[30:0], irq}, "irq_clear");
      kind <= 2'h1;
      wr(`UAP_ADDR_CTRL, 32'h1);
      vbus_pin <= 1'h1;
      cyc(30);
      rd(`UAP_ADDR_STAT);
      ck(1'h0, d[`UAP_STAT_VBUS], "pin_ignored");
      vbus_sense_input <= 1'h1;
      vbus_pin <= 1'h0;
      cyc(90);
      rd(`UAP_ADDR_STAT);
      ck(2'h3, d[1:0], "sense_attach");
      wr(`UAP_ADDR_CTRL, 32'h5);
      ck(2'h0, pwr, "configured");
      wr(`UAP_ADDR_CTRL, 32'hd);
      ck(2'h3, pwr, "suspended");
      ck(map[7:6], chg, "chg_susp");
      wake_in <= 1'h1;
      cyc(12);
      ck(1'h1, remote_wakeup, "wake");
      wake_in <= 1'h0;
      rd(`UAP_ADDR_IRQ_STAT);
      ck(1'h1, d[`UAP_IRQ_WAKE], "irq_wake");
      wr(`UAP_ADDR_CTRL, 32'h083);
      ck(2'h1, led, "led_rx");
      wr(`UAP_ADDR_CTRL, 32'h183);
      ck(2'h0, led, "led_on");
      wr(`UAP_ADDR_CTRL, 32'h203);
      ck(1'h1, line_driver_enable, "drv_on");
      wr(`UAP_ADDR_CTRL, 32'h3);
      ck(1'h0, line_driver_enable, "drv_off");
      cyc(110);
      ck(2'h3, led, "led_off");
      seed = xs(seed);
      wr(`UAP_ADDR_BUTTON, {29'h0, seed[2:0]});
      ck(seed[2:0], btn, "button");
      chip_reset_n <= 1'h0;
      cyc(5);
      ck(2'h0, {pins_oe, usb_plus_pullup_en}, "chip_reset");
      chip_reset_n <= 1'h1;
      cyc(12);
      ck(1'h1, pins_oe, "oe_back");
      end_of_test;
   end
endmodule
